// ==== rtl/smsc_pkg.sv ====
// package of constants and types for the sonar mode and sleep controller
`default_nettype none
package smsc_pkg;
  // ********************
  // timing
  // ********************
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned CMD_IDLE_MIN = 5;
  localparam int unsigned WARN_MIN = 4;
  localparam int unsigned RESUME_MIN = 5;
  localparam int unsigned MAINT_HOURS = 9;
  localparam longint unsigned CYC_PER_MIN = 64'(CLK_HZ) * 64'd60;
  localparam longint unsigned CMD_IDLE_CYC = CYC_PER_MIN * CMD_IDLE_MIN;
  localparam longint unsigned WARN_CYC = CYC_PER_MIN * WARN_MIN;
  localparam longint unsigned RESUME_CYC = CYC_PER_MIN * RESUME_MIN;
  localparam longint unsigned MAINT_CYC = CYC_PER_MIN * 64'd60 * MAINT_HOURS;
  localparam int unsigned BREAK_CYC = 1042;
  localparam int unsigned CNT_W = 40;
  // ********************
  // fault log
  // ********************
  localparam int unsigned FLT_DEPTH = 8;
  localparam int unsigned FLT_IDX_W = 3;
  localparam int unsigned CODE_W = 16;
  localparam int unsigned TIME_W = 32;
  localparam int unsigned PARAM_W = 32;
  localparam int unsigned REC_W = 64;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [7:0] PING_CNT_RST = 8'h01;
  // ********************
  // host commands
  // ********************
  typedef enum logic [3:0] {
    CMD_NONE, CMD_START, CMD_FIRST_PING_TIME, CMD_FAULT_DISPLAY, CMD_FAULT_CLEAR, CMD_OTHER
  } smsc_cmd_t;
  typedef enum {
    ST_SLEEP, ST_CMD_PROMPT, ST_PING_PROMPT, ST_WAIT_FIRST, ST_PING, ST_RECEIVE, ST_SELFTEST,
    ST_SENSOR, ST_OUTPUT, ST_CHARGE, ST_DUMP
  } smsc_state_t;
endpackage
`default_nettype wire

// ==== rtl/smsc_fifo.sv ====
// parameterised valid/ready fifo for ensemble and report records
`default_nettype none
module smsc_fifo #(
  parameter int unsigned WIDTH = 64,
  parameter int unsigned DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_q;
  logic [AW:0] rdPtr_q;
  wire full = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
  wire empty = wrPtr_q == rdPtr_q;
  wire doWr = inValid && !full;
  wire doRd = outReady && !empty;
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rdPtr_q[AW-1:0]];
  always_ff @(posedge sys_clk) begin
    if (doWr) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_q + (AW+1)'(doWr);
      rdPtr_q <= rdPtr_q + (AW+1)'(doRd);
    end
  end
endmodule
`default_nettype wire

// ==== rtl/smsc_ctrl.sv ====
// mode, sleep and wake controller with ping sequencing and fault log
`default_nettype none
module smsc_ctrl #(
  parameter longint unsigned CMD_IDLE_CYC = smsc_pkg::CMD_IDLE_CYC,
  parameter longint unsigned WARN_CYC = smsc_pkg::WARN_CYC,
  parameter longint unsigned RESUME_CYC = smsc_pkg::RESUME_CYC,
  parameter longint unsigned MAINT_CYC = smsc_pkg::MAINT_CYC,
  parameter int unsigned BREAK_CYC = smsc_pkg::BREAK_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic serRx,
  input wire logic cmdValid,
  input wire smsc_pkg::smsc_cmd_t cmdCode,
  input wire logic [7:0] cmdPingCount,
  input wire logic [smsc_pkg::TIME_W-1:0] cmdArg,
  input wire logic resetSwitch,
  input wire logic coldWake,
  input wire logic watchdogWake,
  input wire logic pingAlarmSet,
  input wire logic pingAlarmFire,
  input wire logic [smsc_pkg::TIME_W-1:0] rtcTime,
  input wire logic txDone,
  input wire logic rxDone,
  input wire logic testDone,
  input wire logic sensorDone,
  input wire logic [15:0] echoData,
  input wire logic [15:0] ambTemp,
  input wire logic ambFail,
  input wire logic [15:0] attTemp,
  input wire logic chargeDone,
  input wire logic faultValid,
  input wire logic [smsc_pkg::CODE_W-1:0] faultCode,
  input wire logic [smsc_pkg::PARAM_W-1:0] faultParam,
  input wire logic useRecorder,
  input wire logic outReady,
  output logic awake,
  output logic pingMode,
  output logic promptShown,
  output logic warnSelfDeploy,
  output logic txStart,
  output logic selfTestInject,
  output logic sensorStart,
  output logic chargeEnable,
  output logic [15:0] ambTempOut,
  output logic [15:0] attTempOut,
  output logic [smsc_pkg::REC_W-1:0] outData,
  output logic outSerial,
  output logic outRecorder
);
  // ********************
  // state
  // ********************
  smsc_pkg::smsc_state_t state_q, state_d;
  logic pingMode_q;
  logic tfSet_q;
  logic [smsc_pkg::TIME_W-1:0] tfTime_q;
  logic [7:0] pingCount_q;
  logic [7:0] pingIdx_q;
  logic [23:0] accum_q;
  logic [smsc_pkg::CNT_W-1:0] timer_q;
  logic [15:0] brkCnt_q;
  logic breakSeen_q;
  logic [smsc_pkg::FLT_IDX_W:0] uniq_q;
  logic [15:0] ovfl_q;
  logic [smsc_pkg::TIME_W-1:0] firstT_q, lastT_q;
  logic [smsc_pkg::CODE_W-1:0] fCode [smsc_pkg::FLT_DEPTH];
  logic [15:0] fCount [smsc_pkg::FLT_DEPTH];
  logic [smsc_pkg::TIME_W-1:0] fDelta [smsc_pkg::FLT_DEPTH];
  logic [smsc_pkg::TIME_W-1:0] fTime [smsc_pkg::FLT_DEPTH];
  logic [smsc_pkg::PARAM_W-1:0] fParam [smsc_pkg::FLT_DEPTH];
  logic [smsc_pkg::FLT_IDX_W+2:0] dumpIdx_q;
  logic outValid_q;
  logic [smsc_pkg::REC_W-1:0] rec_q;
  logic fifoInReady, fifoOutValid;
  logic [smsc_pkg::REC_W-1:0] fifoOut;
  logic awake_q, prompt_q, warn_q, tx_q, inj_q, sens_q, chg_q, ser_q, recd_q;
  logic [15:0] amb_q, att_q;
  logic [smsc_pkg::REC_W-1:0] outData_q;

  function automatic logic timerHit(input logic [smsc_pkg::CNT_W-1:0] t, input longint unsigned lim);
    timerHit = 64'(t) >= lim;
  endfunction

  // ********************
  // decode
  // ********************
  wire cmdAny = cmdValid && cmdCode != smsc_pkg::CMD_NONE;
  wire cmdStart = cmdValid && cmdCode == smsc_pkg::CMD_START;
  wire cmdTf = cmdValid && cmdCode == smsc_pkg::CMD_FIRST_PING_TIME;
  wire cmdShow = cmdValid && cmdCode == smsc_pkg::CMD_FAULT_DISPLAY;
  wire cmdClr = cmdValid && cmdCode == smsc_pkg::CMD_FAULT_CLEAR;
  wire breakEv = !serRx && brkCnt_q == 16'(BREAK_CYC) && !breakSeen_q;
  wire tfFuture = tfSet_q && tfTime_q > rtcTime;
  wire tfReached = tfSet_q && rtcTime >= tfTime_q;
  wire lastPing = pingIdx_q + 8'h01 >= pingCount_q;
  wire [15:0] ambSel = ambFail ? attTemp : ambTemp;
  wire dumpLen = dumpIdx_q > {2'b00, uniq_q} * 3'd3 + 6'd1;
  wire stall = !fifoInReady;
  // fault lookup
  logic hitFound;
  logic [smsc_pkg::FLT_IDX_W-1:0] hitIdx;
  always_comb begin
    hitFound = 1'b0;
    hitIdx = '0;
    for (int i = 0; i < smsc_pkg::FLT_DEPTH; i++) begin
      if (!hitFound && i < uniq_q && fCode[i] == faultCode) begin
        hitFound = 1'b1;
        hitIdx = smsc_pkg::FLT_IDX_W'(i);
      end
    end
  end

  // ********************
  // next state
  // ********************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      smsc_pkg::ST_SLEEP: begin
        // wake source decides action
        if (breakEv) begin
          state_d = pingMode_q ? smsc_pkg::ST_PING_PROMPT : smsc_pkg::ST_CMD_PROMPT;
        end else if (coldWake || watchdogWake) begin
          if (!pingMode_q) begin
            state_d = smsc_pkg::ST_CMD_PROMPT;
          end else begin
            state_d = tfFuture ? smsc_pkg::ST_WAIT_FIRST : smsc_pkg::ST_PING;
          end
        end else if (resetSwitch && pingMode_q && !pingAlarmSet) begin
          state_d = tfSet_q ? smsc_pkg::ST_WAIT_FIRST : smsc_pkg::ST_PING;
        end else if (pingMode_q && pingAlarmFire) begin
          state_d = smsc_pkg::ST_PING;
        end else if (timerHit(timer_q, MAINT_CYC)) begin
          state_d = smsc_pkg::ST_CHARGE;
        end
      end
      smsc_pkg::ST_CMD_PROMPT: begin
        if (resetSwitch) begin
          state_d = smsc_pkg::ST_SLEEP;
        end else if (cmdStart) begin
          state_d = tfSet_q ? smsc_pkg::ST_WAIT_FIRST : smsc_pkg::ST_PING;
        end else if (cmdShow) begin
          state_d = smsc_pkg::ST_DUMP;
        end else if (!cmdAny && timerHit(timer_q, CMD_IDLE_CYC)) begin
          state_d = smsc_pkg::ST_SLEEP;
        end
      end
      smsc_pkg::ST_PING_PROMPT: begin
        if (cmdAny) begin
          state_d = smsc_pkg::ST_CMD_PROMPT;
        end else if (resetSwitch) begin
          state_d = pingAlarmSet ? smsc_pkg::ST_SLEEP : (tfSet_q ? smsc_pkg::ST_WAIT_FIRST : smsc_pkg::ST_PING);
        end else if (timerHit(timer_q, RESUME_CYC)) begin
          state_d = smsc_pkg::ST_PING;
        end
      end
      smsc_pkg::ST_WAIT_FIRST: begin
        if (breakEv) begin
          state_d = smsc_pkg::ST_PING_PROMPT;
        end else if (tfReached) begin
          state_d = smsc_pkg::ST_PING;
        end
      end
      smsc_pkg::ST_PING: state_d = txDone ? smsc_pkg::ST_RECEIVE : state_q;
      smsc_pkg::ST_RECEIVE: state_d = rxDone ? smsc_pkg::ST_SELFTEST : state_q;
      smsc_pkg::ST_SELFTEST: state_d = testDone ? smsc_pkg::ST_SENSOR : state_q;
      smsc_pkg::ST_SENSOR: begin
        if (sensorDone) begin
          state_d = lastPing ? smsc_pkg::ST_OUTPUT : smsc_pkg::ST_PING;
        end
      end
      smsc_pkg::ST_OUTPUT: state_d = stall ? state_q : smsc_pkg::ST_SLEEP;
      smsc_pkg::ST_CHARGE: begin
        if (chargeDone) begin
          if (!pingMode_q || pingAlarmSet) begin
            state_d = smsc_pkg::ST_SLEEP;
          end else begin
            state_d = tfFuture ? smsc_pkg::ST_WAIT_FIRST : smsc_pkg::ST_PING;
          end
        end
      end
      smsc_pkg::ST_DUMP: state_d = dumpLen ? smsc_pkg::ST_CMD_PROMPT : state_q;
    endcase
  end
  wire stateChg = state_d != state_q;

  // ********************
  // record for output fifo
  // ********************
  logic [smsc_pkg::REC_W-1:0] dumpRec;
  logic [smsc_pkg::FLT_IDX_W-1:0] dIdx;
  logic [smsc_pkg::FLT_IDX_W+2:0] dOff;
  always_comb begin
    dOff = dumpIdx_q - 6'd2;
    dIdx = smsc_pkg::FLT_IDX_W'(dOff / 6'd3);
    unique case (dumpIdx_q)
      6'd0: dumpRec = {8'h01, 4'h0, uniq_q, 16'h0000, ovfl_q, 16'h0000};
      6'd1: dumpRec = {firstT_q, lastT_q};
      default: begin
        unique case (dOff % 6'd3)
          6'd0: dumpRec = {8'h02, 8'(dIdx), fCode[dIdx], fCount[dIdx], 16'h0000};
          6'd1: dumpRec = {fDelta[dIdx], fTime[dIdx]};
          default: dumpRec = {32'h00000000, fParam[dIdx]};
        endcase
      end
    endcase
  end
  wire pushEns = state_q == smsc_pkg::ST_OUTPUT && !stall;
  wire pushDump = state_q == smsc_pkg::ST_DUMP && !dumpLen && !stall;
  wire [smsc_pkg::REC_W-1:0] ensRec = {8'h03, pingCount_q, ambSel, attTemp, 16'(accum_q / 24'(pingCount_q))};
  wire [smsc_pkg::REC_W-1:0] pushRec = pushEns ? ensRec : dumpRec;

  smsc_fifo #(.WIDTH(smsc_pkg::REC_W), .DEPTH(smsc_pkg::FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .inData(pushRec),
    .inValid(pushEns || pushDump),
    .inReady(fifoInReady),
    .outData(fifoOut),
    .outValid(fifoOutValid),
    .outReady(outReady)
  );

  // ********************
  // sequencing registers
  // ********************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= smsc_pkg::ST_SLEEP;
      timer_q <= '0;
      brkCnt_q <= '0;
      breakSeen_q <= 1'b0;
      pingMode_q <= 1'b0;
      tfSet_q <= 1'b0;
      tfTime_q <= '0;
      pingCount_q <= smsc_pkg::PING_CNT_RST;
      pingIdx_q <= '0;
      accum_q <= '0;
      dumpIdx_q <= '0;
    end else begin
      state_q <= state_d;
      timer_q <= (stateChg || cmdAny) ? '0 : timer_q + 40'h1;
      brkCnt_q <= serRx ? '0 : (brkCnt_q == 16'(BREAK_CYC) ? brkCnt_q : brkCnt_q + 16'h1);
      breakSeen_q <= serRx ? 1'b0 : (breakSeen_q || breakEv);
      if (cmdStart && state_q == smsc_pkg::ST_CMD_PROMPT) begin
        pingMode_q <= 1'b1;
        pingCount_q <= cmdPingCount == 8'h00 ? smsc_pkg::PING_CNT_RST : cmdPingCount;
      end else if (cmdAny && state_q == smsc_pkg::ST_PING_PROMPT) begin
        pingMode_q <= 1'b0;
      end
      if (breakEv) begin
        tfSet_q <= 1'b0;
      end else if (cmdTf) begin
        tfSet_q <= 1'b1;
        tfTime_q <= cmdArg;
      end else if (state_q == smsc_pkg::ST_WAIT_FIRST && tfReached) begin
        tfSet_q <= 1'b0;
      end
      if (state_q == smsc_pkg::ST_SENSOR && sensorDone) begin
        pingIdx_q <= lastPing ? 8'h00 : pingIdx_q + 8'h01;
        accum_q <= accum_q + 24'(echoData);
      end else if (state_q == smsc_pkg::ST_SLEEP) begin
        accum_q <= '0;
      end
      dumpIdx_q <= state_q == smsc_pkg::ST_DUMP ? dumpIdx_q + 6'(pushDump) : '0;
    end
  end

  // ********************
  // fault log
  // ********************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      uniq_q <= '0;
      ovfl_q <= '0;
      firstT_q <= '0;
      lastT_q <= '0;
    end else if (faultValid) begin
      // a clear in the same cycle empties the log and keeps the new fault as its only entry
      lastT_q <= rtcTime;
      if (uniq_q == 0 || cmdClr) begin
        firstT_q <= rtcTime;
      end
      if (cmdClr) begin
        uniq_q <= 4'h1;
        ovfl_q <= '0;
      end else if (!hitFound) begin
        if (uniq_q == 4'(smsc_pkg::FLT_DEPTH)) begin
          ovfl_q <= ovfl_q + 16'h1;
        end else begin
          uniq_q <= uniq_q + 4'h1;
        end
      end
    end else if (cmdClr) begin
      uniq_q <= '0;
      ovfl_q <= '0;
    end
  end
  wire [smsc_pkg::FLT_IDX_W-1:0] wrIdx = (hitFound && !cmdClr) ? hitIdx : (cmdClr ? '0 : uniq_q[2:0]);
  wire wrNew = !(hitFound && !cmdClr);
  always_ff @(posedge sys_clk) begin
    if (faultValid && (!wrNew || cmdClr || uniq_q < 4'(smsc_pkg::FLT_DEPTH))) begin
      fCode[wrIdx] <= faultCode;
      fCount[wrIdx] <= wrNew ? 16'h1 : fCount[wrIdx] + 16'h1;
      fDelta[wrIdx] <= wrNew ? '0 : rtcTime - fTime[wrIdx];
      fTime[wrIdx] <= rtcTime;
      fParam[wrIdx] <= faultParam;
    end
  end

  // ********************
  // registered outputs
  // ********************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      awake_q <= 1'b0;
      prompt_q <= 1'b0;
      warn_q <= 1'b0;
      tx_q <= 1'b0;
      inj_q <= 1'b0;
      sens_q <= 1'b0;
      chg_q <= 1'b0;
      amb_q <= '0;
      att_q <= '0;
      outData_q <= '0;
      outValid_q <= 1'b0;
      ser_q <= 1'b0;
      recd_q <= 1'b0;
    end else begin
      awake_q <= state_d != smsc_pkg::ST_SLEEP && state_d != smsc_pkg::ST_WAIT_FIRST;
      prompt_q <= state_d == smsc_pkg::ST_CMD_PROMPT || state_d == smsc_pkg::ST_PING_PROMPT;
      warn_q <= state_q == smsc_pkg::ST_PING_PROMPT && timerHit(timer_q, WARN_CYC);
      tx_q <= state_d == smsc_pkg::ST_PING;
      inj_q <= state_d == smsc_pkg::ST_SELFTEST;
      sens_q <= state_d == smsc_pkg::ST_SENSOR;
      chg_q <= state_d == smsc_pkg::ST_CHARGE;
      amb_q <= ambSel;
      att_q <= attTemp;
      outValid_q <= fifoOutValid && outReady;
      outData_q <= fifoOut;
      ser_q <= fifoOutValid && outReady && !useRecorder;
      recd_q <= fifoOutValid && outReady && useRecorder;
    end
  end
  assign awake = awake_q;
  assign pingMode = pingMode_q;
  assign promptShown = prompt_q;
  assign warnSelfDeploy = warn_q;
  assign txStart = tx_q;
  assign selfTestInject = inj_q;
  assign sensorStart = sens_q;
  assign chargeEnable = chg_q;
  assign ambTempOut = amb_q;
  assign attTempOut = att_q;
  assign outData = outData_q;
  assign outSerial = ser_q;
  assign outRecorder = recd_q;
endmodule
`default_nettype wire

// ==== testbench/smsc_host_model.sv ====
// host terminal model: break, commands and record sink
`default_nettype none
module smsc_host_model (
  input wire logic sys_clk,
  output logic serRx,
  output logic cmdValid,
  output smsc_pkg::smsc_cmd_t cmdCode,
  output logic [7:0] cmdPingCount,
  output logic [31:0] cmdArg,
  output logic outReady,
  input wire logic outSerial,
  input wire logic outRecorder,
  input wire logic [63:0] outData
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] recs[$];
  initial begin
    serRx = 1'b1;
    cmdValid = 1'b0;
    cmdCode = smsc_pkg::CMD_NONE;
    cmdPingCount = 8'h00;
    cmdArg = 32'h0;
    outReady = 1'b1;
  end
  // space held well past a character time
  task automatic brk();
    @(negedge sys_clk);
    serRx = 1'b0;
    repeat (12) @(negedge sys_clk);
    serRx = 1'b1;
  endtask
  task automatic send(smsc_pkg::smsc_cmd_t cd, logic [7:0] n, logic [31:0] a);
    @(negedge sys_clk);
    cmdValid = 1'b1;
    cmdCode = cd;
    cmdPingCount = n;
    cmdArg = a;
    @(negedge sys_clk);
    cmdValid = 1'b0;
    cmdCode = smsc_pkg::CMD_NONE;
    cmdPingCount = ~n;
    cmdArg = ~a;
  endtask
  task automatic rdy(logic b);
    @(negedge sys_clk);
    outReady = b;
  endtask
  always @(posedge sys_clk) begin
    if (outSerial || outRecorder) begin
      recs.push_back(outData);
    end
  end
endmodule
`default_nettype wire

// ==== testbench/smsc_ctrl_properties.sv ====
// port assertions of the mode and sleep controller
`default_nettype none
module smsc_ctrl_properties #(
  parameter longint unsigned CMD_IDLE_CYC = 200,
  parameter longint unsigned WARN_CYC = 160,
  parameter longint unsigned RESUME_CYC = 200,
  parameter longint unsigned MAINT_CYC = 500,
  parameter int unsigned BREAK_CYC = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic serRx,
  input wire logic cmdValid,
  input wire smsc_pkg::smsc_cmd_t cmdCode,
  input wire logic resetSwitch,
  input wire logic pingAlarmSet,
  input wire logic rxDone,
  input wire logic sensorDone,
  input wire logic ambFail,
  input wire logic chargeDone,
  input wire logic useRecorder,
  input wire logic outReady,
  input wire logic awake,
  input wire logic pingMode,
  input wire logic promptShown,
  input wire logic warnSelfDeploy,
  input wire logic selfTestInject,
  input wire logic chargeEnable,
  input wire logic [15:0] ambTempOut,
  input wire logic [15:0] attTempOut,
  input wire logic outSerial,
  input wire logic outRecorder
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  longint unsigned idleQ, promptQ, lowQ, sleepQ;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idleQ <= 0;
      promptQ <= 0;
      lowQ <= 0;
      sleepQ <= 0;
    end else begin
      idleQ <= (awake && !pingMode && promptShown && !cmdValid) ? idleQ + 1 : 0;
      promptQ <= (awake && pingMode && promptShown && !cmdValid) ? promptQ + 1 : 0;
      lowQ <= serRx ? 0 : lowQ + 1;
      sleepQ <= awake ? 0 : sleepQ + 1;
    end
  end
  chk_idle_sleep: assert property (idleQ <= CMD_IDLE_CYC + 2)
    else $error("idle command mode stayed awake");
  chk_break_prompt: assert property (lowQ == BREAK_CYC + 1 |-> ##[1:4] promptShown)
    else $error("break gave no prompt");
  chk_reset_sleep: assert property (awake && !pingMode && resetSwitch |-> ##[1:2] !awake)
    else $error("reset switch did not sleep");
  chk_start_ping: assert property (promptShown && !pingMode && cmdValid && cmdCode == smsc_pkg::CMD_START
    |-> ##[1:2] pingMode)
    else $error("start did not enter ping mode");
  chk_maint_wake: assert property (sleepQ <= MAINT_CYC + 3)
    else $error("no maintenance wake");
  chk_charge_sleep: assert property (chargeEnable && chargeDone && (!pingMode || pingAlarmSet)
    |-> ##[1:3] !awake)
    else $error("no sleep after charge");
  chk_warn_time: assert property ($rose(warnSelfDeploy) |-> promptQ >= WARN_CYC - 2 && promptQ <= WARN_CYC + 2)
    else $error("warning at wrong time");
  chk_resume_ping: assert property (promptQ <= RESUME_CYC + 2)
    else $error("ping prompt did not resume");
  chk_selftest_after: assert property ($rose(selfTestInject) |-> $past(rxDone) || $past(rxDone, 2))
    else $error("self-test not after reception");
  chk_temp_fallback: assert property (ambFail && sensorDone |-> ##[1:2] ambTempOut == attTempOut)
    else $error("ambient fallback missing");
  chk_out_route: assert property ((outSerial || outRecorder)
    |-> $past(outReady) && outRecorder == $past(useRecorder) && outSerial != outRecorder)
    else $error("record routed wrongly");
  cover property ($rose(warnSelfDeploy));
  cover property (outRecorder);
  cover property ($rose(chargeEnable));
endmodule
bind smsc_ctrl smsc_ctrl_properties #(.CMD_IDLE_CYC(CMD_IDLE_CYC), .WARN_CYC(WARN_CYC), .RESUME_CYC(RESUME_CYC),
  .MAINT_CYC(MAINT_CYC), .BREAK_CYC(BREAK_CYC)) i_smsc_ctrl_properties (.sys_clk, .rst_n, .serRx, .cmdValid,
  .cmdCode, .resetSwitch, .pingAlarmSet, .rxDone, .sensorDone, .ambFail, .chargeDone, .useRecorder, .outReady,
  .awake, .pingMode, .promptShown, .warnSelfDeploy, .selfTestInject, .chargeEnable, .ambTempOut, .attTempOut,
  .outSerial, .outRecorder);
`default_nettype wire

// ==== testbench/smsc_ctrl_tb.sv ====
// self-checking bench for the mode and sleep controller
`default_nettype none
module smsc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int IDLE = 200, WARN = 160, RES = 200, MAINT = 500;
  localparam int AW = 7, PM = 6, PR = 5, WN = 4, TX = 3, CH = 2, OU = 1;
  logic sys_clk = 0, rst_n = 0, resetSwitch = 0, coldWake = 0, watchdogWake = 0, pingAlarmSet = 0;
  logic pingAlarmFire = 0, txDone = 0, rxDone = 0, testDone = 0, sensorDone = 0, ambFail = 0, chargeDone = 0;
  logic faultValid = 0, useRecorder = 0, serRx, cmdValid, outReady, outSerial, outRecorder;
  logic awake, pingMode, promptShown, warnSelfDeploy, txStart, selfTestInject, sensorStart, chargeEnable;
  smsc_pkg::smsc_cmd_t cmdCode;
  logic [7:0] cmdPingCount;
  logic [31:0] cmdArg, rtcTime = 0, faultParam = 0;
  logic [15:0] echoData = 16'h0010, ambTemp = 16'h1111, attTemp = 16'h2222, faultCode = 0, ambTempOut, attTempOut;
  logic [63:0] outData;
  int mismatches = 0, num_checks = 0, c, d;
  wire logic [7:0] obs = {awake, pingMode, promptShown, warnSelfDeploy, txStart, chargeEnable,
    outSerial | outRecorder, 1'b0};
  smsc_ctrl #(.CMD_IDLE_CYC(IDLE), .WARN_CYC(WARN), .RESUME_CYC(RES), .MAINT_CYC(MAINT), .BREAK_CYC(8)) i_smsc_ctrl (
    .sys_clk, .rst_n, .serRx, .cmdValid, .cmdCode, .cmdPingCount, .cmdArg, .resetSwitch, .coldWake, .watchdogWake,
    .pingAlarmSet, .pingAlarmFire, .rtcTime, .txDone, .rxDone, .testDone, .sensorDone, .echoData, .ambTemp, .ambFail,
    .attTemp, .chargeDone, .faultValid, .faultCode, .faultParam, .useRecorder, .outReady, .awake, .pingMode,
    .promptShown, .warnSelfDeploy, .txStart, .selfTestInject, .sensorStart, .chargeEnable, .ambTempOut, .attTempOut,
    .outData, .outSerial, .outRecorder);
  smsc_host_model i_smsc_host_model (.sys_clk, .serRx, .cmdValid, .cmdCode, .cmdPingCount, .cmdArg, .outReady,
    .outSerial, .outRecorder, .outData);
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  // front end answers each ping phase, clock ticks
  always @(negedge sys_clk) begin
    rtcTime <= rtcTime + 1;
    txDone <= txStart && !txDone;
    rxDone <= txDone;
    testDone <= selfTestInject && !testDone;
    sensorDone <= sensorStart && !sensorDone;
    if (sensorDone) begin
      echoData <= echoData + 16'h0020;
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [63:0] e, logic [63:0] s);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rng(string n, int lo, int hi, int s);
    num_checks++;
    if (s < lo || s > hi) begin
      mismatches++;
      $display("[ERR] %s expected %0d..%0d seen %0d", n, lo, hi, s);
    end
  endtask
  task automatic wt(int b, logic v, int n, output int k);
    k = 0;
    while (obs[b] !== v) begin
      @(negedge sys_clk);
      k++;
      if (k > n) begin
        chk("wait bit", 64'(b), 64'hff);
        stop_test();
      end
    end
  endtask
  task automatic pls(ref logic s);
    @(negedge sys_clk);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
  endtask
  task automatic s_idle();
    i_smsc_host_model.brk();
    wt(PR, 1, 30, c);
    repeat (150) @(negedge sys_clk);
    i_smsc_host_model.send(smsc_pkg::CMD_OTHER, 0, 0);
    repeat (150) @(negedge sys_clk);
    chk("awake", 1, awake);
    wt(AW, 0, 100, c);
    rng("idle", IDLE - 152, IDLE - 145, c);
  endtask
  task automatic s_cold();
    pls(coldWake);
    wt(PR, 1, 5, c);
    chk("mode", 0, pingMode);
  endtask
  task automatic s_rsw();
    pls(resetSwitch);
    wt(AW, 0, 3, c);
  endtask
  task automatic s_fault();
    i_smsc_host_model.brk();
    wt(PR, 1, 30, c);
    i_smsc_host_model.rdy(0);
    for (int i = 0; i < 9; i++) begin
      @(negedge sys_clk);
      faultValid = 1;
      faultCode = 16'h0a00 + 16'(i);
      faultParam = 32'(i);
      @(negedge sys_clk);
      faultValid = 0;
    end
    i_smsc_host_model.send(smsc_pkg::CMD_FAULT_DISPLAY, 0, 0);
    repeat (40) @(negedge sys_clk);
    chk("stalled", 0, 64'(i_smsc_host_model.recs.size()));
    i_smsc_host_model.rdy(1);
    repeat (60) @(negedge sys_clk);
    chk("records", 26, 64'(i_smsc_host_model.recs.size()));
    chk("head", 8'h01, i_smsc_host_model.recs[0][63:56]);
    chk("entry", 8'h02, i_smsc_host_model.recs[2][63:56]);
    i_smsc_host_model.recs.delete();
    i_smsc_host_model.send(smsc_pkg::CMD_FAULT_CLEAR, 0, 0);
    i_smsc_host_model.send(smsc_pkg::CMD_FAULT_DISPLAY, 0, 0);
    repeat (30) @(negedge sys_clk);
    chk("cleared", 2, 64'(i_smsc_host_model.recs.size()));
  endtask
  task automatic s_ens();
    ambFail = 1;
    i_smsc_host_model.send(smsc_pkg::CMD_START, 2, 0);
    wt(TX, 1, 3, c);
    wt(OU, 1, 200, c);
    chk("ensemble", {8'h03, 8'h02, attTemp, attTemp, 16'h0020}, outData);
    chk("serial", 1, outSerial);
    chk("amb", attTemp, ambTempOut);
    chk("att", attTemp, attTempOut);
    wt(AW, 0, 10, c);
    chk("mode", 1, pingMode);
  endtask
  task automatic s_pbrk();
    useRecorder = 1;
    i_smsc_host_model.brk();
    wt(PR, 1, 30, c);
    chk("mode", 1, pingMode);
    wt(WN, 1, WARN + 10, c);
    rng("warn", WARN - 12, WARN + 2, c);
    wt(TX, 1, RES, d);
    rng("resume", RES - 12, RES + 2, c + d);
    wt(OU, 1, 200, c);
    chk("record", {8'h03, 8'h02, attTemp, attTemp, 16'h0060}, outData);
    chk("route", 1, outRecorder);
    wt(AW, 0, 10, c);
  endtask
  task automatic s_charge();
    pingAlarmSet = 1;
    wt(CH, 1, MAINT + 10, c);
    rng("maint", MAINT - 12, MAINT + 3, c);
    pls(chargeDone);
    wt(AW, 0, 4, c);
    chk("mode", 1, pingMode);
  endtask
  task automatic s_prst();
    pls(resetSwitch);
    repeat (3) @(negedge sys_clk);
    chk("asleep", 0, {awake, txStart});
    pingAlarmSet = 0;
    pls(resetSwitch);
    wt(TX, 1, 4, c);
    wt(OU, 1, 200, c);
    wt(AW, 0, 10, c);
  endtask
  task automatic s_pcmd();
    i_smsc_host_model.brk();
    wt(PR, 1, 30, c);
    i_smsc_host_model.send(smsc_pkg::CMD_OTHER, 0, 0);
    wt(PM, 0, 3, c);
  endtask
  task automatic s_tf();
    i_smsc_host_model.send(smsc_pkg::CMD_FIRST_PING_TIME, 0, rtcTime + 40);
    i_smsc_host_model.send(smsc_pkg::CMD_START, 2, 0);
    repeat (4) @(negedge sys_clk);
    chk("waiting", 2'b10, {pingMode, txStart});
    wt(TX, 1, 40, c);
    rng("first ping", 24, 36, c);
    wt(OU, 1, 200, c);
    wt(AW, 0, 10, c);
  endtask
  task automatic s_cping();
    pls(coldWake);
    wt(TX, 1, 4, c);
    wt(OU, 1, 200, c);
    wt(AW, 0, 10, c);
    pls(pingAlarmFire);
    wt(TX, 1, 4, c);
    wt(OU, 1, 200, c);
    wt(AW, 0, 10, c);
    pls(watchdogWake);
    wt(TX, 1, 4, c);
    wt(OU, 1, 200, c);
  endtask
  initial begin
    repeat (16) @(negedge sys_clk);
    rst_n = 1;
    chk("reset", 0, {awake, pingMode, promptShown});
    s_idle();
    s_cold();
    s_rsw();
    s_fault();
    s_ens();
    s_pbrk();
    s_charge();
    s_prst();
    s_pcmd();
    s_tf();
    s_cping();
    stop_test();
  end
endmodule
`default_nettype wire
